//--- hdl/urx_cfg.svh
`ifndef URX_CFG_SVH
`define URX_CFG_SVH
`define URX_OFF_CTRL 8'h00
`define URX_OFF_ERR_EN 8'h04
`define URX_OFF_ERR_FLAG 8'h08
`define URX_OFF_RXDATA 8'h0c
`define URX_OFF_TXDATA 8'h10
`define URX_OFF_ADDR_TX 8'h14
`define URX_OFF_MATCH 8'h18
`define URX_OFF_MASK 8'h1c
`define URX_OFF_STATUS 8'h20
// ctrl: [0] on, [1] receiver_enable, [2] tx enable, [3] run_on_overflow, [7:4] mode
`define URX_CTRL_ON 0
`define URX_CTRL_RECEIVER_ENABLE 1
`define URX_CTRL_TXEN 2
`define URX_CTRL_RUN_ON_OVERFLOW 3
`define URX_MODE_ODD 4'h2
`define URX_MODE_EVEN 4'h3
`define URX_MODE_ADDR 4'h4
// error bits shared by enable and flag registers; [3] flag: transmitter idle with both transmit buffers empty
`define URX_ERR_FE 0
`define URX_ERR_PE 1
`define URX_ERR_OVF 2
`define URX_ERR_TXMT 3
`define URX_OS_LAST 4'hf
`define URX_FIFO_DEPTH 2'd2
`define URX_RESP_OKAY 2'b00
`define URX_RESP_SLVERR 2'b10
`endif

//--- hdl/urx_err_addr.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "urx_cfg.svh"
module urx_err_addr #(
  parameter logic [15:0] CLKS_PER_OS = 16'd68
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // serial line
  input wire logic rx_in,
  output logic tx_out,
  // status outputs
  output logic receive_ready_flag,
  output logic summary_error_interrupt
);
  urx_pkg::urx_state_t s_q;
  urx_pkg::urx_state_t s_d;

  function automatic logic maj_low(input logic [1:0] lows);
    maj_low = lows >= 2'd2;
  endfunction : maj_low

  function automatic logic os_sample(input logic [3:0] os);
    os_sample = (os == 4'd7) || (os == 4'd8) || (os == 4'd9);
  endfunction : os_sample

  logic tick;
  logic empty;
  urx_pkg::urx_entry_t top;
  logic top_fe;
  logic top_pe;
  logic nine;

  assign tick = s_q.div == 16'd0;
  assign empty = s_q.cnt == 2'd0;
  assign top = s_q.fifo[s_q.rd_ptr];
  assign top_fe = !empty && top[8];
  assign top_pe = !empty && top[9];
  assign nine = (s_q.mode == `URX_MODE_ODD) || (s_q.mode == `URX_MODE_EVEN) || (s_q.mode == `URX_MODE_ADDR);

  // ready and the frame/parity terms are views of the oldest entry, so popping or flushing clears them for free; ovf stays until written clear
  assign receive_ready_flag = !empty && !(s_q.fe_en && top_fe) && !(s_q.pe_en && top_pe);
  assign summary_error_interrupt = (s_q.fe_en && top_fe) || (s_q.pe_en && top_pe)
                                   || (s_q.ovf_en && s_q.ovf);
  assign tx_out = s_q.tx_out;
  assign s_axi_awready = !s_q.aw_v;
  assign s_axi_wready = !s_q.w_v;
  assign s_axi_bvalid = s_q.b_v;
  assign s_axi_bresp = s_q.b_resp;
  assign s_axi_arready = !s_q.r_v;
  assign s_axi_rvalid = s_q.r_v;
  assign s_axi_rdata = s_q.r_d;
  assign s_axi_rresp = s_q.r_resp;

  always_comb begin
    logic rx_run;
    logic done;
    logic fe;
    logic pe;
    logic store;
    logic push;
    logic pop;
    logic bit_v;
    logic ovf_clr;
    logic [7:0] wd;
    s_d = s_q;
    rx_run = 1'b0;
    done = 1'b0;
    fe = 1'b0;
    pe = 1'b0;
    store = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    bit_v = 1'b0;
    ovf_clr = 1'b0;
    wd = s_q.w_d[7:0];

    s_d.div = tick ? CLKS_PER_OS - 16'd1 : s_q.div - 16'd1;

    // register writes, taken once both address and data have arrived
    if (s_axi_awvalid && !s_q.aw_v) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_v) begin
      s_d.w_v = 1'b1;
      s_d.w_d = s_axi_wdata;
      s_d.w_s = s_axi_wstrb;
    end
    if (s_q.b_v && s_axi_bready) begin
      s_d.b_v = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v && !s_q.b_v) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.b_v = 1'b1;
      s_d.b_resp = `URX_RESP_OKAY;
      unique case (s_q.aw_a)
        `URX_OFF_CTRL: if (s_q.w_s[0]) begin
          s_d.on = wd[`URX_CTRL_ON];
          s_d.receiver_enable = wd[`URX_CTRL_RECEIVER_ENABLE];
          s_d.txen = wd[`URX_CTRL_TXEN];
          s_d.run_on_overflow = wd[`URX_CTRL_RUN_ON_OVERFLOW];
          s_d.mode = wd[7:4];
        end
        `URX_OFF_ERR_EN: if (s_q.w_s[0]) begin
          s_d.fe_en = wd[`URX_ERR_FE];
          s_d.pe_en = wd[`URX_ERR_PE];
          s_d.ovf_en = wd[`URX_ERR_OVF];
        end
        // only the overflow flag is writable, and only towards zero
        `URX_OFF_ERR_FLAG: ovf_clr = s_q.w_s[0] && !wd[`URX_ERR_OVF];
        `URX_OFF_TXDATA: if (s_q.w_s[0]) begin
          s_d.txb = wd;
          s_d.txb_full = 1'b1;
        end
        `URX_OFF_ADDR_TX: if (s_q.w_s[0]) begin
          s_d.p1 = wd;
          s_d.p1_full = 1'b1;
        end
        `URX_OFF_MATCH: if (s_q.w_s[0]) begin
          s_d.match = wd;
        end
        `URX_OFF_MASK: if (s_q.w_s[0]) begin
          s_d.mask = wd;
        end
        `URX_OFF_RXDATA, `URX_OFF_STATUS: ;
        default: s_d.b_resp = `URX_RESP_SLVERR;
      endcase
    end

    // register reads; a read of receive data pops the fifo
    if (s_q.r_v && s_axi_rready) begin
      s_d.r_v = 1'b0;
    end
    if (s_axi_arvalid && !s_q.r_v) begin
      s_d.r_v = 1'b1;
      s_d.r_d = 32'h0;
      s_d.r_resp = `URX_RESP_OKAY;
      unique case (s_axi_araddr)
        `URX_OFF_CTRL: s_d.r_d[7:0] = {s_q.mode, s_q.run_on_overflow, s_q.txen, s_q.receiver_enable, s_q.on};
        `URX_OFF_ERR_EN: s_d.r_d[2:0] = {s_q.ovf_en, s_q.pe_en, s_q.fe_en};
        `URX_OFF_ERR_FLAG: s_d.r_d[3:0] = {s_q.tx_st == urx_pkg::TX_IDLE && !s_q.txb_full && !s_q.p1_full,
                                           s_q.ovf, top_pe, top_fe};
        `URX_OFF_RXDATA: begin
          s_d.r_d[7:0] = empty ? 8'h0 : top[7:0];
          pop = !empty;
        end
        `URX_OFF_MATCH: s_d.r_d[7:0] = s_q.match;
        `URX_OFF_MASK: s_d.r_d[7:0] = s_q.mask;
        `URX_OFF_STATUS: s_d.r_d[4:0] = {s_q.cnt, s_q.p1_full, s_q.txb_full, receive_ready_flag};
        `URX_OFF_TXDATA, `URX_OFF_ADDR_TX: ;
        default: s_d.r_resp = `URX_RESP_SLVERR;
      endcase
    end

    // receiver: 16 oversample ticks per bit, majority of samples 7, 8 and 9
    rx_run = s_q.on && s_q.receiver_enable && !(s_q.ovf && !s_q.run_on_overflow);
    if (!rx_run) begin
      s_d.rx_st = urx_pkg::RX_IDLE;
    end else if (tick) begin
      s_d.rx_os = s_q.rx_os + 4'd1;
      if (os_sample(s_q.rx_os) && !rx_in) begin
        s_d.rx_low = s_q.rx_low + 2'd1;
      end
      unique case (s_q.rx_st)
        urx_pkg::RX_IDLE: begin
          s_d.rx_os = 4'd0;
          s_d.rx_low = 2'd0;
          if (!rx_in) begin
            s_d.rx_st = urx_pkg::RX_START;
          end
        end
        urx_pkg::RX_START: begin
          if (s_q.rx_os == `URX_OS_LAST) begin
            s_d.rx_low = 2'd0;
            s_d.rx_nb = 4'd0;
            // a start bit that is mostly high was a glitch; drop it silently
            s_d.rx_st = maj_low(s_q.rx_low) ? urx_pkg::RX_BITS : urx_pkg::RX_IDLE;
          end
        end
        urx_pkg::RX_BITS: begin
          if (s_q.rx_os == `URX_OS_LAST) begin
            bit_v = !maj_low(s_q.rx_low);
            s_d.rx_sh[s_q.rx_nb] = bit_v;
            s_d.rx_low = 2'd0;
            s_d.rx_nb = s_q.rx_nb + 4'd1;
            if (s_q.rx_nb == (nine ? 4'd8 : 4'd7)) begin
              s_d.rx_st = urx_pkg::RX_STOP;
            end
          end
        end
        urx_pkg::RX_STOP: begin
          // finish mid stop bit so the next falling edge is not missed
          if (s_q.rx_os == 4'd9) begin
            done = 1'b1;
            s_d.rx_st = urx_pkg::RX_IDLE;
          end
        end
      endcase
    end

    if (done) begin
      fe = maj_low(s_d.rx_low);
      if (s_q.mode == `URX_MODE_EVEN) begin
        pe = ^s_q.rx_sh;
      end else if (s_q.mode == `URX_MODE_ODD) begin
        pe = ~^s_q.rx_sh;
      end else if (s_q.mode == `URX_MODE_ADDR) begin
        pe = s_q.rx_sh[8];
      end
      if (!nine) begin
        s_d.rx_sh[8] = 1'b0;
      end
      store = 1'b1;
      if (s_q.mode == `URX_MODE_ADDR) begin
        if (s_q.rx_sh[8]) begin
          store = ((s_q.rx_sh[7:0] ^ s_q.match) & s_q.mask) == 8'h0;
          s_d.addr_ok = store;
        end else begin
          store = s_q.addr_ok;
        end
      end
      if (store) begin
        // with run-on set, the shifter keeps going but nothing lands while full
        if (s_q.cnt == `URX_FIFO_DEPTH) begin
          s_d.ovf = 1'b1;
        end else begin
          push = 1'b1;
        end
      end
    end

    // a new overflow in the clearing cycle still wins
    if (ovf_clr && !(done && store && s_q.cnt == `URX_FIFO_DEPTH)) begin
      s_d.ovf = 1'b0;
    end

    if (push) begin
      s_d.fifo[s_q.wr_ptr] = {pe, fe, s_q.rx_sh[7:0]};
      s_d.wr_ptr = !s_q.wr_ptr;
    end
    if (pop) begin
      s_d.rd_ptr = !s_q.rd_ptr;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};

    // transmitter
    if (tick && s_q.tx_st == urx_pkg::TX_SHIFT) begin
      s_d.tx_os = s_q.tx_os + 4'd1;
      if (s_q.tx_os == `URX_OS_LAST) begin
        s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
        s_d.tx_out = s_q.tx_sh[1];
        s_d.tx_nb = s_q.tx_nb - 4'd1;
        if (s_q.tx_nb == 4'd1) begin
          s_d.tx_st = urx_pkg::TX_IDLE;
          s_d.tx_out = 1'b1;
        end
      end
    end else if (tick && s_q.on && s_q.txen && s_q.tx_st == urx_pkg::TX_IDLE) begin
      s_d.tx_os = 4'd0;
      if (s_q.p1_full && s_q.mode == `URX_MODE_ADDR) begin
        s_d.tx_sh = {1'b1, 1'b1, s_q.p1, 1'b0};
        s_d.tx_nb = 4'd11;
        s_d.p1_full = 1'b0;
        s_d.tx_st = urx_pkg::TX_SHIFT;
        s_d.tx_out = 1'b0;
      end else if (s_q.txb_full) begin
        if (s_q.mode == `URX_MODE_ADDR) begin
          s_d.tx_sh = {1'b1, 1'b0, s_q.txb, 1'b0};
        end else if (s_q.mode == `URX_MODE_EVEN) begin
          s_d.tx_sh = {1'b1, ^s_q.txb, s_q.txb, 1'b0};
        end else if (s_q.mode == `URX_MODE_ODD) begin
          s_d.tx_sh = {1'b1, ~^s_q.txb, s_q.txb, 1'b0};
        end else begin
          s_d.tx_sh = {1'b1, 1'b1, s_q.txb, 1'b0};
        end
        s_d.tx_nb = nine ? 4'd11 : 4'd10;
        s_d.txb_full = 1'b0;
        s_d.tx_st = urx_pkg::TX_SHIFT;
        s_d.tx_out = 1'b0;
      end
    end

    if (!s_q.receiver_enable) begin
      s_d.addr_ok = 1'b0;
    end
    // flush in the same cycle as the write that clears on, so ready never outlives it
    if (!s_d.on) begin
      s_d.cnt = 2'd0;
      s_d.rd_ptr = 1'b0;
      s_d.wr_ptr = 1'b0;
      s_d.addr_ok = 1'b0;
      s_d.tx_st = urx_pkg::TX_IDLE;
      s_d.tx_out = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rx_st <= urx_pkg::RX_IDLE;
      s_q.tx_st <= urx_pkg::TX_IDLE;
      s_q.tx_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : urx_err_addr

//--- hdl/urx_pkg.sv
package urx_pkg;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS = 4'b0100,
    RX_STOP = 4'b1000
  } urx_rx_st_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } urx_tx_st_t;
  // fifo entry: [7:0] data, [8] framing error, [9] parity error or ninth bit
  typedef logic [9:0] urx_entry_t;
  typedef struct packed {
    logic [15:0] div;
    logic on;
    logic receiver_enable;
    logic txen;
    logic run_on_overflow;
    logic [3:0] mode;
    logic fe_en;
    logic pe_en;
    logic ovf_en;
    logic ovf;
    logic [7:0] match;
    logic [7:0] mask;
    urx_entry_t [1:0] fifo;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] cnt;
    logic addr_ok;
    urx_rx_st_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_nb;
    logic [1:0] rx_low;
    logic [8:0] rx_sh;
    urx_tx_st_t tx_st;
    logic [3:0] tx_os;
    logic [3:0] tx_nb;
    logic [10:0] tx_sh;
    logic tx_out;
    logic txb_full;
    logic [7:0] txb;
    logic p1_full;
    logic [7:0] p1;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic b_v;
    logic [1:0] b_resp;
    logic r_v;
    logic [1:0] r_resp;
    logic [31:0] r_d;
  } urx_state_t;
endpackage : urx_pkg

//--- verif/urx_err_addr_checker.sv
`timescale 1ns/1ps
`include "urx_cfg.svh"
module urx_err_addr_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // status
  input wire logic receive_ready_flag,
  input wire logic summary_error_interrupt
);
  logic [7:0] ar_q, aw_q, w_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_q <= 8'h00;
      aw_q <= 8'h00;
      w_q <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer missing");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // address and data are both held, with their readies low, in the cycle before the response
  property p_aw_refuse;
    $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write answered before address and data held");
  property p_unmapped;
    $rose(s_axi_rvalid) && ar_q > 8'h20 |-> s_axi_rresp == `URX_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  // no ready and no summary can only mean an empty fifo
  property p_empty_clean;
    $rose(s_axi_rvalid) && ar_q == `URX_OFF_ERR_FLAG && !$past(receive_ready_flag)
      && !$past(summary_error_interrupt) |-> s_axi_rdata[1:0] == 2'b00;
  endproperty
  a_empty_clean: assert property (p_empty_clean) else $error("flags set on empty fifo");
  property p_status;
    $rose(s_axi_rvalid) && ar_q == `URX_OFF_STATUS |-> s_axi_rdata[4:3] <= 2'd2
      && (s_axi_rdata[4:3] != 2'd0 || !s_axi_rdata[0]);
  endproperty
  a_status: assert property (p_status) else $error("fifo count wrong");
  property p_off_flush;
    $rose(s_axi_bvalid) && aw_q == `URX_OFF_CTRL && !w_q[0] |-> !receive_ready_flag;
  endproperty
  a_off_flush: assert property (p_off_flush) else $error("fifo kept after off");
  property p_en_off;
    $rose(s_axi_bvalid) && aw_q == `URX_OFF_ERR_EN && w_q[2:0] == 3'b000 |-> !summary_error_interrupt;
  endproperty
  a_en_off: assert property (p_en_off) else $error("summary without enable");
endmodule : urx_err_addr_checker
bind urx_err_addr urx_err_addr_checker u_chk (
  .clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .receive_ready_flag(receive_ready_flag),
  .summary_error_interrupt(summary_error_interrupt));

//--- verif/urx_err_addr_tb_top.sv
`timescale 1ns/1ps
`include "urx_cfg.svh"
module urx_err_addr_tb_top;
  localparam logic [15:0] OS = 16'd2;
  localparam logic [7:0] MSK = 8'hf0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, adr_m;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrd, bv, arr, rv, rdy, sei, rxl, txl, match_m;
  logic ovf_m = 1'b0;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] en_m;
  logic [3:0] mode_m;
  logic [9:0] q[$];
  int fail_count = 0, checks = 0;
  always #4 clk = ~clk;
  urx_node #(.BIT_CLKS(16 * OS)) u_node (.clk(clk), .line_o(rxl), .line_i(txl));
  urx_err_addr #(.CLKS_PER_OS(OS)) DUT (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'b000),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'b000),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .rx_in(rxl), .tx_out(txl), .receive_ready_flag(rdy), .summary_error_interrupt(sei));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // handshake flags are sampled mid-cycle, so the edge's own updates never race
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    awa <= a;
    wd <= d;
    forever begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wrd;
      tb = bv & br;
      resp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) begin
        br <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, t;
    @(posedge clk);
    arv <= 1'b1;
    rr <= 1'b1;
    ara <= a;
    forever begin
      @(negedge clk);
      ta = arv & arr;
      t = rv & rr;
      d = rdat;
      resp = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (t) begin
        rr <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rx(input logic [8:0] d, input logic stop);
    logic ok;
    u_node.send(d, (mode_m inside {4'h2, 4'h3, 4'h4}) ? 9 : 8, stop);
    if (!ovf_m && mode_m == `URX_MODE_ADDR && d[8]) match_m = ((d[7:0] ^ adr_m) & MSK) == 8'h00;
    ok = !ovf_m && (mode_m != `URX_MODE_ADDR || match_m);
    if (ok && q.size() == 2) ovf_m = 1'b1;
    else if (ok) q.push_back({mode_m == 4 ? d[8] : mode_m == 3 ? ^d : mode_m == 2 ? ~^d : 1'b0, !stop, d[7:0]});
  endtask : rx
  task automatic pop_chk;
    logic [31:0] v;
    logic [9:0] e;
    e = q.size() ? q[0] : 10'h000;
    @(negedge clk);
    chk(rdy, q.size() && !(en_m[0] && e[8]) && !(en_m[1] && e[9]));
    chk(sei, |(en_m & {ovf_m, e[9:8]}));
    rd(`URX_OFF_STATUS, v);
    chk(v[4:3], q.size());
    rd(`URX_OFF_ERR_FLAG, v);
    chk(v[2:0], {ovf_m, e[9:8]});
    rd(`URX_OFF_RXDATA, v);
    chk(v, e[7:0]);
    if (q.size()) void'(q.pop_front());
  endtask : pop_chk
  task automatic cfg(input logic [3:0] m, input logic run, input logic [2:0] en);
    wr(`URX_OFF_CTRL, 32'h0);
    q.delete();
    match_m = 1'b0;
    wr(`URX_OFF_ERR_EN, {29'h0, en});
    wr(`URX_OFF_CTRL, {24'h0, m, run, 3'b111});
    en_m = en;
    mode_m = m;
  endtask : cfg
  task automatic clr;
    wr(`URX_OFF_ERR_FLAG, 32'h0);
    ovf_m = 1'b0;
  endtask : clr
  initial begin
    logic [31:0] v;
    logic [7:0] b;
    void'($urandom(63));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cfg(4'h0, 1'b0, 3'b111);
    rx(9'($urandom), 1'b1);
    rx(9'($urandom), 1'b0);
    rx(9'($urandom), 1'b1);
    pop_chk();
    rx(9'($urandom), 1'b1);
    wr(`URX_OFF_ERR_FLAG, 32'h7);
    repeat (2) pop_chk();
    clr();
    cfg(4'h0, 1'b1, 3'b000);
    repeat (3) rx(9'($urandom), 1'b1);
    clr();
    rx(9'($urandom), 1'b1);
    repeat (3) pop_chk();
    clr();
    rx(9'($urandom), 1'b1);
    pop_chk();
    // left in the fifo so that the next switch-off must flush a visible character
    rx(9'($urandom), 1'b1);
    for (int i = 0; i < 4; i++) begin
      cfg(4'h2 + 4'(i[1]), 1'b0, 3'b010);
      b = 8'($urandom);
      rx({^b ^ !i[1] ^ i[0], b}, 1'b1);
      pop_chk();
    end
    cfg(`URX_MODE_ADDR, 1'b0, 3'b010);
    adr_m = 8'($urandom);
    wr(`URX_OFF_MATCH, {24'h0, adr_m});
    wr(`URX_OFF_MASK, {24'h0, MSK});
    rx({1'b0, 8'($urandom)}, 1'b1);
    rx({1'b1, adr_m ^ 8'h05}, 1'b1);
    rx({1'b0, 8'($urandom)}, 1'b1);
    rx({1'b1, adr_m ^ 8'h50}, 1'b1);
    rx({1'b0, 8'($urandom)}, 1'b1);
    repeat (3) pop_chk();
    rx({1'b1, adr_m}, 1'b1);
    cfg(`URX_MODE_ADDR, 1'b0, 3'b010);
    pop_chk();
    b = 8'($urandom);
    wr(`URX_OFF_TXDATA, {24'h0, ~b});
    wr(`URX_OFF_TXDATA, {24'h0, b});
    wr(`URX_OFF_ADDR_TX, {24'h0, adr_m});
    for (int i = 0; i < 5000 && u_node.got_q.size() < 3; i++) @(posedge clk);
    chk(u_node.got_q.size(), 3);
    chk(u_node.got_q[0], {1'b0, ~b});
    chk(u_node.got_q[1], {1'b1, adr_m});
    chk(u_node.got_q[2], {1'b0, b});
    rd(8'h24, v);
    chk(v, 32'h0);
    chk(resp, `URX_RESP_SLVERR);
    give_verdict();
  end
endmodule : urx_err_addr_tb_top

//--- verif/urx_node.sv
`timescale 1ns/1ps
module urx_node #(
  parameter int BIT_CLKS = 32
) (
  // serial line
  input wire logic clk,
  output logic line_o,
  input wire logic line_i
);
  logic [8:0] got_q[$];
  initial line_o = 1'b1;
  // a low stop bit provokes a framing error; one idle bit follows each frame
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    for (int i = 0; i < n + 3; i++) begin
      @(posedge clk);
      line_o <= i == 0 ? 1'b0 : i <= n ? d[i - 1] : i == n + 1 ? stop : 1'b1;
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask : send
  // nine-bit frames only; the ninth bit is the address mark
  initial forever begin : catch
    logic [8:0] r;
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      r[i] = line_i;
    end
    got_q.push_back(r);
  end
endmodule : urx_node
